/* File: rtl/dofm_top.sv */
// Purpose: Digital output function selector with AXI4-Lite registers
// Assumes: Status inputs come from logic on clk_sys; index pulse is async
// Notes:   Pulse generator is external; its drive enters on pulse_gen_in
//
// How it works
// - Two relays, open-collector and pulse output each have a selector.
// - Pulse output works as pulse generator or plain on/off output.
// - Same code on several outputs, each follows independently.
// - Code 0 holds the output off.
// - Codes 1-4 follow running, forward, reverse and jog with frequency output.
// - Code 5 follows drive fault.
// - Codes 6-8 follow level detects A, B and frequency reached.
// - Code 9 needs output and reference frequency both zero.
// - Codes 10 and 11 follow upper and lower limit reached.
// - Code 12 needs both powers up and no protection active.
// - Code 13 follows pre-excitation in progress.
// - Codes 14 and 15 follow overload and underload pre-alarms.
// - Codes 16 and 17 follow sequencer stage and cycle done.
// - Codes 23, 24, 25, 34 mirror fieldbus virtual bits.
// - Code 26 follows bus voltage above undervoltage threshold.
// - Code 27 asserts on index pulse, clears 10 ms later.
// - Code 28 follows pulse superposition active.
// - Code 29 follows safe torque off fault.
// - Codes 30-32 follow positioning, spindle zeroing, scale-division done.
// - Code 33 follows frequency held at a limit.
// - Pulse type 0 selects pulse mode, 1 on/off, default 0.
// - Reset selects code 1 on relay A, 5 on relay B, 0 elsewhere.
`include "dofm_map.svh"

module dofm_top (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Drive status conditions
	input  wire logic        st_run,
	input  wire logic        st_run_fwd,
	input  wire logic        st_run_rev,
	input  wire logic        st_jog,
	input  wire logic        st_freq_out,
	input  wire logic        st_fault,
	input  wire logic        freq_level_detect_a,
	input  wire logic        freq_level_detect_b,
	input  wire logic        st_freq_reached,
	input  wire logic        st_out_freq_zero,
	input  wire logic        st_ref_freq_zero,
	input  wire logic        st_upper_lim,
	input  wire logic        st_lower_lim,
	input  wire logic        st_main_pwr_ok,
	input  wire logic        st_ctrl_pwr_ok,
	input  wire logic        st_protect_active,
	input  wire logic        st_preexcite,
	input  wire logic        st_overload_pre,
	input  wire logic        st_underload_pre,
	input  wire logic        st_seq_stage_done,
	input  wire logic        st_seq_cycle_done,
	input  wire logic        st_bus_above_uv,
	input  wire logic        enc_index_pin,
	input  wire logic        st_pulse_sup,
	input  wire logic        safe_torque_off,
	input  wire logic        st_pos_done,
	input  wire logic        st_spindle_zero_done,
	input  wire logic        st_spindle_div_done,
	input  wire logic        st_freq_limited,
	input  wire logic        pulse_gen_in,
	// Output terminals
	output logic             relay_output_a,
	output logic             relay_output_b,
	output logic             oc_output,
	output logic             pulse_capable_output
);

	// ==========================================
	// Registers
	dofm_pkg::dofm_sel_t     sel_a_reg;
	dofm_pkg::dofm_sel_t     sel_b_reg;
	dofm_pkg::dofm_sel_t     sel_oc_reg;
	dofm_pkg::dofm_sel_t     sel_p_reg;
	dofm_pkg::dofm_ptype_e   ptype_reg;
	logic [3:0]              vbits_reg;
	dofm_pkg::dofm_wstate_e  wstate_reg;
	logic                    aw_seen_reg;
	logic                    w_seen_reg;
	logic [11:0]             awaddr_reg;
	logic [31:0]             wdata_reg;
	logic                    wstrb0_reg;
	logic [1:0]              idx_sync_reg;
	logic                    idx_prev_reg;
	logic                    idx_hold_reg;
	logic [17:0]             idx_cnt_reg;

	// ==========================================
	// Write channel
	wire        aw_fire   = s_axi_awvalid & s_axi_awready;
	wire        w_fire    = s_axi_wvalid & s_axi_wready;
	wire        aw_have   = aw_seen_reg | aw_fire;
	wire        w_have    = w_seen_reg | w_fire;
	wire [11:0] wr_addr   = aw_fire ? s_axi_awaddr : awaddr_reg;
	wire [31:0] wr_data   = w_fire ? s_axi_wdata : wdata_reg;
	wire        wr_strb0  = w_fire ? s_axi_wstrb[0] : wstrb0_reg;
	wire        wr_do     = (wstate_reg == dofm_pkg::DOFM_WS_IDLE) & aw_have & w_have;
	wire        wr_en     = wr_do & wr_strb0;
	wire        wr_sel_a  = wr_addr == `DOFM_OFF_SEL_RELAY_A;
	wire        wr_sel_b  = wr_addr == `DOFM_OFF_SEL_RELAY_B;
	wire        wr_sel_oc = wr_addr == `DOFM_OFF_SEL_OC;
	wire        wr_sel_p  = wr_addr == `DOFM_OFF_SEL_PULSE;
	wire        wr_ptype  = wr_addr == `DOFM_OFF_PULSE_TYPE;
	wire        wr_vbits  = wr_addr == `DOFM_OFF_VBITS;
	wire        wr_mapped = wr_sel_a | wr_sel_b | wr_sel_oc | wr_sel_p | wr_ptype | wr_vbits
		| (wr_addr == `DOFM_OFF_STATUS);
	wire [5:0]  wr_code   = wr_data[`DOFM_SEL_MSB:0];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_seen_reg   <= 1'b0;
			w_seen_reg    <= 1'b0;
			awaddr_reg    <= 12'h000;
			wdata_reg     <= 32'h00000000;
			wstrb0_reg    <= 1'b0;
			wstate_reg    <= dofm_pkg::DOFM_WS_IDLE;
		end else begin
			s_axi_awready <= (wstate_reg == dofm_pkg::DOFM_WS_IDLE) & ~aw_have & ~wr_do;
			s_axi_wready  <= (wstate_reg == dofm_pkg::DOFM_WS_IDLE) & ~w_have & ~wr_do;
			if (aw_fire) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_reg  <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
			unique case (wstate_reg)
				dofm_pkg::DOFM_WS_IDLE: begin
					aw_seen_reg <= aw_have & ~wr_do;
					w_seen_reg  <= w_have & ~wr_do;
					if (wr_do) begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
						wstate_reg   <= dofm_pkg::DOFM_WS_RESP;
					end
				end
				dofm_pkg::DOFM_WS_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wstate_reg   <= dofm_pkg::DOFM_WS_IDLE;
					end
				end
				default: begin
					wstate_reg <= dofm_pkg::DOFM_WS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_a_reg  <= `DOFM_RST_SEL_RELAY_A;
			sel_b_reg  <= `DOFM_RST_SEL_RELAY_B;
			sel_oc_reg <= `DOFM_RST_SEL_OC;
			sel_p_reg  <= `DOFM_RST_SEL_PULSE;
			ptype_reg  <= dofm_pkg::dofm_ptype_e'(`DOFM_RST_PULSE_TYPE);
			vbits_reg  <= 4'h0;
		end else if (wr_en) begin
			if (wr_sel_a) begin
				sel_a_reg <= wr_code;
			end
			if (wr_sel_b) begin
				sel_b_reg <= wr_code;
			end
			if (wr_sel_oc) begin
				sel_oc_reg <= wr_code;
			end
			if (wr_sel_p) begin
				sel_p_reg <= wr_code;
			end
			if (wr_ptype) begin
				ptype_reg <= dofm_pkg::dofm_ptype_e'(wr_data[0]);
			end
			if (wr_vbits) begin
				vbits_reg <= wr_data[3:0];
			end
		end
	end

	// ==========================================
	// Read channel
	wire [31:0] status_word = {28'h0000000, pulse_capable_output, oc_output,
		relay_output_b, relay_output_a};
	wire [11:0] ra          = s_axi_araddr;
	wire        rd_mapped   = (ra == `DOFM_OFF_SEL_RELAY_A) | (ra == `DOFM_OFF_SEL_RELAY_B)
		| (ra == `DOFM_OFF_SEL_OC) | (ra == `DOFM_OFF_SEL_PULSE)
		| (ra == `DOFM_OFF_PULSE_TYPE) | (ra == `DOFM_OFF_VBITS) | (ra == `DOFM_OFF_STATUS);
	wire [31:0] rd_word     =
		(ra == `DOFM_OFF_SEL_RELAY_A) ? {26'h0, sel_a_reg} :
		(ra == `DOFM_OFF_SEL_RELAY_B) ? {26'h0, sel_b_reg} :
		(ra == `DOFM_OFF_SEL_OC)      ? {26'h0, sel_oc_reg} :
		(ra == `DOFM_OFF_SEL_PULSE)   ? {26'h0, sel_p_reg} :
		(ra == `DOFM_OFF_PULSE_TYPE)  ? {31'h0, ptype_reg} :
		(ra == `DOFM_OFF_VBITS)       ? {28'h0000000, vbits_reg} :
		(ra == `DOFM_OFF_STATUS)      ? status_word : 32'h00000000;
	wire        ar_fire     = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~ar_fire & ~s_axi_arready;
			if (ar_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_mapped ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Index pulse stretcher
	// Hold 10 ms from index edge; a new edge restarts the hold
	wire idx_edge = idx_sync_reg[1] & ~idx_prev_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			idx_sync_reg <= 2'b00;
			idx_prev_reg <= 1'b0;
			idx_hold_reg <= 1'b0;
			idx_cnt_reg  <= 18'h00000;
		end else begin
			idx_sync_reg <= {idx_sync_reg[0], enc_index_pin};
			idx_prev_reg <= idx_sync_reg[1];
			if (idx_edge) begin
				idx_hold_reg <= 1'b1;
				idx_cnt_reg  <= 18'(`DOFM_INDEX_HOLD_CYC - 1);
			end else if (idx_cnt_reg != 18'h00000) begin
				idx_cnt_reg <= idx_cnt_reg - 18'h00001;
			end else begin
				idx_hold_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Condition vector, indexed by function code
	logic [63:0] cond;

	always_comb begin
		cond = 64'h0000000000000000;
		cond[dofm_pkg::DOFM_F_RUN]       = st_run & st_freq_out;
		cond[dofm_pkg::DOFM_F_RUN_FWD]   = st_run_fwd & st_freq_out;
		cond[dofm_pkg::DOFM_F_RUN_REV]   = st_run_rev & st_freq_out;
		cond[dofm_pkg::DOFM_F_JOG]       = st_jog & st_freq_out;
		cond[dofm_pkg::DOFM_F_FAULT]     = st_fault;
		cond[dofm_pkg::DOFM_F_FLVL_A]    = freq_level_detect_a;
		cond[dofm_pkg::DOFM_F_FLVL_B]    = freq_level_detect_b;
		cond[dofm_pkg::DOFM_F_FREACH]    = st_freq_reached;
		cond[dofm_pkg::DOFM_F_ZERO_SPD]  = st_out_freq_zero & st_ref_freq_zero;
		cond[dofm_pkg::DOFM_F_UPPER_LIM] = st_upper_lim;
		cond[dofm_pkg::DOFM_F_LOWER_LIM] = st_lower_lim;
		cond[dofm_pkg::DOFM_F_READY]     = st_main_pwr_ok & st_ctrl_pwr_ok & ~st_protect_active;
		cond[dofm_pkg::DOFM_F_PREEXC]    = st_preexcite;
		cond[dofm_pkg::DOFM_F_OVL_PRE]   = st_overload_pre;
		cond[dofm_pkg::DOFM_F_UDL_PRE]   = st_underload_pre;
		cond[dofm_pkg::DOFM_F_SEQ_STAGE] = st_seq_stage_done;
		cond[dofm_pkg::DOFM_F_SEQ_CYCLE] = st_seq_cycle_done;
		cond[dofm_pkg::DOFM_F_VB_MODBUS] = vbits_reg[`DOFM_VBIT_MODBUS];
		cond[dofm_pkg::DOFM_F_VB_CANBUS] = vbits_reg[`DOFM_VBIT_CANBUS];
		cond[dofm_pkg::DOFM_F_VB_ETH]    = vbits_reg[`DOFM_VBIT_ETH];
		cond[dofm_pkg::DOFM_F_VB_RTETH]  = vbits_reg[`DOFM_VBIT_RTETH];
		cond[dofm_pkg::DOFM_F_BUS_OK]    = st_bus_above_uv;
		cond[dofm_pkg::DOFM_F_INDEX]     = idx_hold_reg;
		cond[dofm_pkg::DOFM_F_PULSE_SUP] = st_pulse_sup;
		cond[dofm_pkg::DOFM_F_STO]       = safe_torque_off;
		cond[dofm_pkg::DOFM_F_POS_DONE]  = st_pos_done;
		cond[dofm_pkg::DOFM_F_SPZ_DONE]  = st_spindle_zero_done;
		cond[dofm_pkg::DOFM_F_SPDIV_DONE] = st_spindle_div_done;
		cond[dofm_pkg::DOFM_F_FREQ_LIM]  = st_freq_limited;
		cond[dofm_pkg::DOFM_F_NONE]      = 1'b0;
	end

	// ==========================================
	// Output selection
	// Independent lookups; unset codes read as zero
	wire out_a_next  = cond[sel_a_reg];
	wire out_b_next  = cond[sel_b_reg];
	wire out_oc_next = cond[sel_oc_reg];
	// Pulse mode passes generator, on/off mode passes function
	wire out_p_next  = (ptype_reg == dofm_pkg::DOFM_PT_PULSE) ? pulse_gen_in : cond[sel_p_reg];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			relay_output_a       <= 1'b0;
			relay_output_b       <= 1'b0;
			oc_output            <= 1'b0;
			pulse_capable_output <= 1'b0;
		end else begin
			relay_output_a       <= out_a_next;
			relay_output_b       <= out_b_next;
			oc_output            <= out_oc_next;
			pulse_capable_output <= out_p_next;
		end
	end

endmodule

/* File: rtl/dofm_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: AXI4-Lite register bus, 32-bit words
// Notes:   Definitions only
`ifndef DOFM_MAP_SVH
`define DOFM_MAP_SVH

// ==========================================
// Register offsets
`define DOFM_OFF_SEL_RELAY_A  12'h000
`define DOFM_OFF_SEL_RELAY_B  12'h004
`define DOFM_OFF_SEL_OC       12'h008
`define DOFM_OFF_SEL_PULSE    12'h00c
`define DOFM_OFF_PULSE_TYPE   12'h010
`define DOFM_OFF_VBITS        12'h014
`define DOFM_OFF_STATUS       12'h018

// ==========================================
// Field positions
`define DOFM_SEL_MSB          5
`define DOFM_VBIT_MODBUS      0
`define DOFM_VBIT_CANBUS      1
`define DOFM_VBIT_ETH         2
`define DOFM_VBIT_RTETH       3

// ==========================================
// Reset values
`define DOFM_RST_SEL_RELAY_A  6'h01
`define DOFM_RST_SEL_RELAY_B  6'h05
`define DOFM_RST_SEL_OC       6'h00
`define DOFM_RST_SEL_PULSE    6'h00
`define DOFM_RST_PULSE_TYPE   1'h0

// ==========================================
// Timing
`define DOFM_CLK_HZ           25000000
`define DOFM_INDEX_HOLD_MS    10
`define DOFM_INDEX_HOLD_CYC   ((`DOFM_CLK_HZ / 1000) * `DOFM_INDEX_HOLD_MS)

`endif

/* File: rtl/dofm_pkg.sv */
// Purpose: Types shared by the output function selector
// Assumes: Constants live in dofm_map.svh
// Notes:   Codes 18-22 and 35 upward are not decoded
package dofm_pkg;

	typedef logic [5:0] dofm_sel_t;

	typedef enum logic [5:0] {
		DOFM_F_NONE      = 6'h00,
		DOFM_F_RUN       = 6'h01,
		DOFM_F_RUN_FWD   = 6'h02,
		DOFM_F_RUN_REV   = 6'h03,
		DOFM_F_JOG       = 6'h04,
		DOFM_F_FAULT     = 6'h05,
		DOFM_F_FLVL_A    = 6'h06,
		DOFM_F_FLVL_B    = 6'h07,
		DOFM_F_FREACH    = 6'h08,
		DOFM_F_ZERO_SPD  = 6'h09,
		DOFM_F_UPPER_LIM = 6'h0a,
		DOFM_F_LOWER_LIM = 6'h0b,
		DOFM_F_READY     = 6'h0c,
		DOFM_F_PREEXC    = 6'h0d,
		DOFM_F_OVL_PRE   = 6'h0e,
		DOFM_F_UDL_PRE   = 6'h0f,
		DOFM_F_SEQ_STAGE = 6'h10,
		DOFM_F_SEQ_CYCLE = 6'h11,
		DOFM_F_VB_MODBUS = 6'h17,
		DOFM_F_VB_CANBUS = 6'h18,
		DOFM_F_VB_ETH    = 6'h19,
		DOFM_F_BUS_OK    = 6'h1a,
		DOFM_F_INDEX     = 6'h1b,
		DOFM_F_PULSE_SUP = 6'h1c,
		DOFM_F_STO       = 6'h1d,
		DOFM_F_POS_DONE  = 6'h1e,
		DOFM_F_SPZ_DONE  = 6'h1f,
		DOFM_F_SPDIV_DONE = 6'h20,
		DOFM_F_FREQ_LIM  = 6'h21,
		DOFM_F_VB_RTETH  = 6'h22
	} dofm_func_e;

	typedef enum logic [0:0] {
		DOFM_PT_PULSE = 1'b0,
		DOFM_PT_ONOFF = 1'b1
	} dofm_ptype_e;

	typedef enum logic [1:0] {
		DOFM_WS_IDLE = 2'b00,
		DOFM_WS_RESP = 2'b01
	} dofm_wstate_e;

endpackage

/* File: tb/dofm_checker.sv */
// Purpose: Bus and reset assertions for the output selector
// Assumes: Bound onto dofm_top, one clock domain
// Notes:   Sees only top-level ports
module dofm_checker (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        relay_output_a,
	input wire logic        relay_output_b,
	input wire logic        oc_output,
	input wire logic        pulse_capable_output
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ==========================================
	// Write channel
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer)
		else $error("write response missing");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop)
		else $error("write response repeated");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write taken while response pending");

	// ==========================================
	// Read channel
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read data missing");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed while stalled");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read taken while data pending");

	// ==========================================
	// Terminals after reset
	property p_rst_off;
		$fell(rst) |-> !relay_output_a && !relay_output_b && !oc_output && !pulse_capable_output;
	endproperty
	a_rst_off: assert property (p_rst_off)
		else $error("terminal on right after reset");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_relay_b: cover property ($rose(relay_output_b));
endmodule

bind dofm_top dofm_checker u_dofm_checker (.*);

/* File: tb/dofm_load_model.sv */
// Purpose: Relays and loads wired to the output terminals
// Assumes: Contacts settle one clock after the drive changes
// Notes:   No contact bounce modelled
module dofm_load_model (
	input wire logic  clk_sys,
	input wire logic  relay_output_a,
	input wire logic  relay_output_b,
	input wire logic  oc_output,
	input wire logic  pulse_capable_output,
	output logic [3:0] closed
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_sys) begin
		closed <= {pulse_capable_output, oc_output, relay_output_b, relay_output_a};
	end
endmodule

/* File: tb/test_digital_output_function_mux.sv */
// Purpose: Self-checking bench for the output function selector
// Assumes: Register offsets as in dofm_map.svh
// Notes:   Index hold is only checked to start and to last 1000 cycles, its full 10 ms is too long here
module test_digital_output_function_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        enc_index_pin = 1'h0, pulse_gen_in = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hf, closed;
	logic [27:0] st = 28'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        relay_output_a, relay_output_b, oc_output, pulse_capable_output;
	int          error_cnt = 0, total_checks = 0;

	always #20 clk_sys = ~clk_sys;

	dofm_top u_dofm_top (.*, .st_run(st[0]), .st_run_fwd(st[1]), .st_run_rev(st[2]),
		.st_jog(st[3]), .st_freq_out(st[4]), .st_fault(st[5]), .freq_level_detect_a(st[6]),
		.freq_level_detect_b(st[7]), .st_freq_reached(st[8]), .st_out_freq_zero(st[9]),
		.st_ref_freq_zero(st[10]), .st_upper_lim(st[11]), .st_lower_lim(st[12]),
		.st_main_pwr_ok(st[13]), .st_ctrl_pwr_ok(st[14]), .st_protect_active(st[15]),
		.st_preexcite(st[16]), .st_overload_pre(st[17]), .st_underload_pre(st[18]),
		.st_seq_stage_done(st[19]), .st_seq_cycle_done(st[20]), .st_bus_above_uv(st[21]),
		.st_pulse_sup(st[22]), .safe_torque_off(st[23]), .st_pos_done(st[24]),
		.st_spindle_zero_done(st[25]), .st_spindle_div_done(st[26]), .st_freq_limited(st[27]));
	dofm_load_model u_dofm_load_model (.*);

	// ==========================================
	// Shared tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic tmo(input int n);
		if (n >= 50) begin
			error_cnt++;
			stop_test;
		end
	endtask

	// Response ready raised only once valid is seen, so a stall occurs
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		tmo(n);
	endtask

	task automatic rdr(input logic [11:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		tmo(n);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] exp [6] = '{32'h1, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			rdr(12'(i * 4));
			chk("reset register", exp[i], rd);
			chk("mapped read resp", 32'h0, 32'(rsp));
		end
		st <= 28'h21;
		tick(3);
		chk("relay a without freq", 32'h0, 32'(relay_output_a));
		chk("relay b fault", 32'h1, 32'(relay_output_b));
		$display("test reset done");
	endtask

	task automatic t_codes;
		logic [34:0] tb [32] = '{{6'h01, 1'h1, 28'h11}, {6'h01, 1'h0, 28'h1},
			{6'h02, 1'h1, 28'h12}, {6'h03, 1'h1, 28'h14}, {6'h04, 1'h1, 28'h18},
			{6'h05, 1'h1, 28'h20}, {6'h06, 1'h1, 28'h40}, {6'h07, 1'h1, 28'h80},
			{6'h08, 1'h1, 28'h100}, {6'h09, 1'h1, 28'h600}, {6'h09, 1'h0, 28'h200},
			{6'h0a, 1'h1, 28'h800}, {6'h0b, 1'h1, 28'h1000}, {6'h0c, 1'h1, 28'h6000},
			{6'h0c, 1'h0, 28'he000}, {6'h0d, 1'h1, 28'h10000}, {6'h0e, 1'h1, 28'h20000},
			{6'h0f, 1'h1, 28'h40000}, {6'h10, 1'h1, 28'h80000}, {6'h11, 1'h1, 28'h100000},
			{6'h1a, 1'h1, 28'h200000}, {6'h1c, 1'h1, 28'h400000}, {6'h1d, 1'h1, 28'h800000},
			{6'h1e, 1'h1, 28'h1000000}, {6'h1f, 1'h1, 28'h2000000}, {6'h20, 1'h1, 28'h4000000},
			{6'h21, 1'h1, 28'h8000000}, {6'h00, 1'h0, 28'hfffffff}, {6'h12, 1'h0, 28'hfffffff},
			{6'h16, 1'h0, 28'hfffffff}, {6'h23, 1'h0, 28'hfffffff}, {6'h3f, 1'h0, 28'hfffffff}};
		logic [5:0] vb [4] = '{6'h17, 6'h18, 6'h19, 6'h22};
		for (int i = 0; i < 32; i++) begin
			wr(12'h008, 32'(tb[i][34:29]));
			chk("select write resp", 32'h0, 32'(rsp));
			st <= tb[i][27:0];
			tick(3);
			chk("oc on", 32'(tb[i][28]), 32'(oc_output));
			st <= 28'h0;
			tick(3);
			chk("oc condition gone", 32'h0, 32'(oc_output));
		end
		for (int i = 0; i < 4; i++) begin
			wr(12'h008, 32'(vb[i]));
			wr(12'h014, 32'h1 << i);
			tick(3);
			chk("virtual bit set", 32'h1, 32'(oc_output));
			wr(12'h014, ~(32'h1 << i) & 32'hf);
			tick(3);
			chk("virtual bit clear", 32'h0, 32'(oc_output));
		end
		$display("test codes done");
	endtask

	task automatic t_shared;
		wr(12'h010, 32'h1);
		for (int i = 0; i < 4; i++) wr(12'(i * 4), 32'h5);
		st <= 28'h20;
		tick(3);
		chk("all on fault", 32'hf, {28'h0, pulse_capable_output, oc_output, relay_output_b,
			relay_output_a});
		chk("loads closed", 32'hf, 32'(closed));
		wr(12'h010, 32'h0);
		tick(3);
		chk("pulse mode ignores code", 32'h0, 32'(pulse_capable_output));
		pulse_gen_in <= 1'h1;
		tick(3);
		chk("pulse mode follows generator", 32'h1, 32'(pulse_capable_output));
		pulse_gen_in <= 1'h0;
		tick(3);
		$display("test shared done");
	endtask

	task automatic t_bus;
		rdr(12'h018);
		chk("status", 32'h7, rd);
		wr(12'h018, 32'h0);
		chk("status write resp", 32'h0, 32'(rsp));
		// Byte lane 0 off: write answered but dropped
		s_axi_wstrb <= 4'he;
		wr(12'h000, 32'h3);
		s_axi_wstrb <= 4'hf;
		chk("masked write resp", 32'h0, 32'(rsp));
		rdr(12'h000);
		chk("masked write ignored", 32'h5, rd);
		wr(12'h01c, 32'h5);
		chk("unmapped write resp", 32'h2, 32'(rsp));
		rdr(12'h01c);
		chk("unmapped read resp", 32'h2, 32'(rsp));
		chk("unmapped read data", 32'h0, rd);
		st <= 28'h0;
		$display("test bus done");
	endtask

	task automatic t_index;
		wr(12'h008, 32'h1b);
		tick(3);
		chk("index idle", 32'h0, 32'(oc_output));
		enc_index_pin <= 1'h1;
		tick(8);
		chk("index start", 32'h1, 32'(oc_output));
		enc_index_pin <= 1'h0;
		tick(1000);
		chk("index held", 32'h1, 32'(oc_output));
		$display("test index done");
	endtask

	initial begin
		tick(20);
		rst <= 1'h0;
		tick(2);
		t_reset;
		t_codes;
		t_shared;
		t_bus;
		t_index;
		stop_test;
	end

	initial begin
		#4000000;
		error_cnt++;
		stop_test;
	end
endmodule
